// ==== src/ffmd_top.sv ====
// free-fall / high-g motion detector with its four threshold and debounce registers
// assumes a byte register port from the serial front end and synchronous axis samples
`timescale 1ns/100ps
module ffmd_top
   import ffmd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port from serial front end
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   // axis samples
   input wire logic sample_valid,
   input wire logic [SAMPLE_BITS-1:0] x_sample,
   input wire logic [SAMPLE_BITS-1:0] y_sample,
   input wire logic [SAMPLE_BITS-1:0] z_sample,
   // control bits held elsewhere in the device
   input wire logic debounce_rate_sel_lo,
   input wire logic debounce_rate_sel_hi,
   input wire logic freefall_irq_enable,
   input wire logic freefall_latch_mode,
   input wire logic motion_latch_mode,
   input wire logic motion_enable_pin,
   // flags
   output logic freefall_flag,
   output logic motion_flag,
   output logic irq_out
);
   import ffmd_pkg::*;

   // ---------------------------------------------
   // register file
   // ---------------------------------------------
   logic [7:0] freefall_threshold_reg;
   logic [7:0] freefall_debounce_reg;
   logic [7:0] motion_threshold_reg;
   logic [7:0] motion_debounce_reg;
   logic [7:0] addr_base;

   // spi read addresses carry bit 7; strip it so both forms decode
   assign addr_base = reg_addr & ~SPI_READ_BIT;

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == FF_THRESH_ADDR) || (a == FF_DEBOUNCE_ADDR) ||
                  (a == MOT_THRESH_ADDR) || (a == MOT_DEBOUNCE_ADDR);
   endfunction

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         freefall_threshold_reg <= FF_THRESH_RST;
         freefall_debounce_reg <= FF_DEBOUNCE_RST;
         motion_threshold_reg <= MOT_THRESH_RST;
         motion_debounce_reg <= MOT_DEBOUNCE_RST;
      end else if (reg_wr) begin
         case (addr_base)
            FF_THRESH_ADDR: freefall_threshold_reg <= reg_wdata;
            FF_DEBOUNCE_ADDR: freefall_debounce_reg <= reg_wdata;
            MOT_THRESH_ADDR: motion_threshold_reg <= reg_wdata;
            MOT_DEBOUNCE_ADDR: motion_debounce_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read data registered; unmapped reads return zero
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         reg_hit <= (reg_rd || reg_wr) && is_mapped(addr_base);
         if (reg_rd) begin
            case (addr_base)
               FF_THRESH_ADDR: reg_rdata <= freefall_threshold_reg;
               FF_DEBOUNCE_ADDR: reg_rdata <= freefall_debounce_reg;
               MOT_THRESH_ADDR: reg_rdata <= motion_threshold_reg;
               MOT_DEBOUNCE_ADDR: reg_rdata <= motion_debounce_reg;
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // pin synchronisers
   // ---------------------------------------------
   logic [5:0] pin_meta_reg;
   logic [5:0] pin_sync_reg;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_reg <= 6'h00;
         pin_sync_reg <= 6'h00;
      end else begin
         pin_meta_reg <= {debounce_rate_sel_hi, debounce_rate_sel_lo, freefall_irq_enable,
                          freefall_latch_mode, motion_latch_mode, motion_enable_pin};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   logic [1:0] rate_sel;
   logic ff_en;
   logic ff_lat;
   logic mot_lat;
   logic mot_en;
   assign rate_sel = pin_sync_reg[5:4];
   assign ff_en = pin_sync_reg[3];
   assign ff_lat = pin_sync_reg[2];
   assign mot_lat = pin_sync_reg[1];
   assign mot_en = pin_sync_reg[0];

   // ---------------------------------------------
   // debounce rate tick
   // ---------------------------------------------
   logic [TICK_W-1:0] tick_cnt_reg;
   logic [TICK_W-1:0] tick_period;
   logic tick;
   always_comb begin
      case (rate_sel)
         2'b00: tick_period = RATE0_CYC;
         2'b01: tick_period = RATE1_CYC;
         2'b10: tick_period = RATE2_CYC;
         default: tick_period = RATE3_CYC;
      endcase
   end
   assign tick = (tick_cnt_reg >= tick_period - TICK_W'(1));
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_reg <= '0;
      end else if (tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      end
   end

   // ---------------------------------------------
   // axis capture and comparison
   // ---------------------------------------------
   logic [SAMPLE_BITS-1:0] axis_reg [3];
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         axis_reg[0] <= '0;
         axis_reg[1] <= '0;
         axis_reg[2] <= '0;
      end else if (sample_valid) begin
         axis_reg[0] <= x_sample;
         axis_reg[1] <= y_sample;
         axis_reg[2] <= z_sample;
      end
   end

   logic [SAMPLE_BITS-1:0] ff_limit;
   logic [SAMPLE_BITS-1:0] mot_limit;
   assign ff_limit = {freefall_threshold_reg, {THRESH_SHIFT{1'b0}}};
   assign mot_limit = {motion_threshold_reg, {THRESH_SHIFT{1'b0}}};

   logic [2:0] below;
   logic [2:0] above;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_axis
         assign below[g] = axis_reg[g] < ff_limit;
         assign above[g] = axis_reg[g] > mot_limit;
      end
   endgenerate

   // ---------------------------------------------
   // debounce channels
   // ---------------------------------------------
   ffmd_det_if ff_ch();
   ffmd_det_if mot_ch();
   assign ff_ch.tick = tick;
   assign ff_ch.qualify = &below;
   assign ff_ch.debounce = freefall_debounce_reg;
   assign mot_ch.tick = tick;
   assign mot_ch.qualify = |above;
   assign mot_ch.debounce = motion_debounce_reg;

   ffmd_debounce u_ff_deb (.ref_clk(ref_clk), .reset_n(reset_n), .det(ff_ch.chan));
   ffmd_debounce u_mot_deb (.ref_clk(ref_clk), .reset_n(reset_n), .det(mot_ch.chan));

   // ---------------------------------------------
   // latching and output
   // ---------------------------------------------
   logic ff_latched_reg;
   logic mot_latched_reg;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ff_latched_reg <= 1'b0;
      end else if (!ff_en) begin
         ff_latched_reg <= 1'b0;
      end else if (ff_ch.detected) begin
         ff_latched_reg <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mot_latched_reg <= 1'b0;
      end else if (!mot_en) begin
         mot_latched_reg <= 1'b0;
      end else if (mot_ch.detected) begin
         mot_latched_reg <= 1'b1;
      end
   end

   // enable gates the output; detection itself keeps running
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         freefall_flag <= 1'b0;
         motion_flag <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         freefall_flag <= ff_en && (ff_lat ? (ff_latched_reg || ff_ch.detected)
                                           : ff_ch.detected);
         motion_flag <= mot_en && (mot_lat ? (mot_latched_reg || mot_ch.detected)
                                           : mot_ch.detected);
         irq_out <= (ff_en && (ff_lat ? (ff_latched_reg || ff_ch.detected) : ff_ch.detected))
                    || (mot_en && (mot_lat ? (mot_latched_reg || mot_ch.detected)
                                           : mot_ch.detected));
      end
   end
endmodule

// ==== src/ffmd_pkg.sv ====
// package: register map, reset values, timing constants for the free-fall / motion detector
// assumes a 125 MHz reference clock and 12-bit unsigned axis samples
package ffmd_pkg;
   localparam logic [7:0] FF_THRESH_ADDR = 8'h08;
   localparam logic [7:0] FF_DEBOUNCE_ADDR = 8'h09;
   localparam logic [7:0] MOT_THRESH_ADDR = 8'h0A;
   localparam logic [7:0] MOT_DEBOUNCE_ADDR = 8'h0B;
   localparam logic [7:0] SPI_READ_BIT = 8'h80;
   localparam logic [7:0] FF_THRESH_RST = 8'h0E;
   localparam logic [7:0] FF_DEBOUNCE_RST = 8'h01;
   localparam logic [7:0] MOT_THRESH_RST = 8'h55;
   localparam logic [7:0] MOT_DEBOUNCE_RST = 8'h01;
   localparam int SAMPLE_BITS = 12;
   localparam int THRESH_SHIFT = 4;
   localparam int CLK_HZ = 125000000;
   localparam int RATE0_HZ = 250;
   localparam int RATE1_HZ = 1000;
   localparam int RATE2_HZ = 4000;
   localparam int RATE3_HZ = 16000;
   localparam int TICK_W = 20;
   localparam logic [TICK_W-1:0] RATE0_CYC = TICK_W'(CLK_HZ / RATE0_HZ);
   localparam logic [TICK_W-1:0] RATE1_CYC = TICK_W'(CLK_HZ / RATE1_HZ);
   localparam logic [TICK_W-1:0] RATE2_CYC = TICK_W'(CLK_HZ / RATE2_HZ);
   localparam logic [TICK_W-1:0] RATE3_CYC = TICK_W'(CLK_HZ / RATE3_HZ);
   typedef enum logic [2:0] {
      DET_IDLE = 3'b001,
      DET_COUNT = 3'b010,
      DET_HIT = 3'b100
   } det_state_t;
endpackage

// ==== src/ffmd_det_if.sv ====
// interface: one debounce channel, between detector top and debounce counter
// assumes one clock domain, driven by the top
`timescale 1ns/100ps
interface ffmd_det_if;
   logic tick;
   logic qualify;
   logic [7:0] debounce;
   logic detected;
   modport top (output tick, output qualify, output debounce, input detected);
   modport chan (input tick, input qualify, input debounce, output detected);
endinterface

// ==== src/ffmd_debounce.sv ====
// debounce counter: counts consecutive qualifying samples up to the programmed value
// assumes tick is a one-cycle pulse at the selected debounce rate
`timescale 1ns/100ps
module ffmd_debounce
   import ffmd_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // channel
   ffmd_det_if.chan det
);
   import ffmd_pkg::*;
   det_state_t state_reg;
   det_state_t state_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      if (det.tick) begin
         if (!det.qualify) begin
            state_next = DET_IDLE;
            count_next = 8'h00;
         end else begin
            case (state_reg)
               DET_IDLE, DET_COUNT: begin
                  // count reaching the register value raises the flag
                  if (count_reg + 8'h01 >= det.debounce || det.debounce == 8'h00) begin
                     state_next = DET_HIT;
                  end else begin
                     state_next = DET_COUNT;
                     count_next = count_reg + 8'h01;
                  end
               end
               DET_HIT: state_next = DET_HIT;
               default: state_next = DET_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= DET_IDLE;
         count_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   assign det.detected = (state_reg == DET_HIT);
endmodule

// ==== dv/ffmd_top_assertions.sv ====
// checker: port-level properties of the free-fall / motion detector
// assumes it is bound into ffmd_top and sees only its ports
`timescale 1ns/100ps
module ffmd_top_assertions (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit,
   // samples
   input wire logic sample_valid,
   input wire logic [ffmd_pkg::SAMPLE_BITS-1:0] x_sample,
   input wire logic [ffmd_pkg::SAMPLE_BITS-1:0] y_sample,
   input wire logic [ffmd_pkg::SAMPLE_BITS-1:0] z_sample,
   // control pins
   input wire logic debounce_rate_sel_lo,
   input wire logic debounce_rate_sel_hi,
   input wire logic freefall_irq_enable,
   input wire logic freefall_latch_mode,
   input wire logic motion_latch_mode,
   input wire logic motion_enable_pin,
   // flags
   input wire logic freefall_flag,
   input wire logic motion_flag,
   input wire logic irq_out
);
   import ffmd_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ----
   // properties
   // ----
   // bit7 is the read form of the address, so only bits 6:0 decode
   wire mapped = reg_addr[6:2] == 5'h02;
   sequence wr_s;
      reg_wr && mapped;
   endsequence
   sequence rd_same_s;
      reg_rd && !reg_wr && reg_addr[6:0] == $past(reg_addr[6:0]);
   endsequence
   irq_or_a: assert property (irq_out == (freefall_flag || motion_flag))
      else $error("irq line not the OR of flags");
   map_hit_a: assert property ((reg_wr || reg_rd) && mapped |=> reg_hit)
      else $error("mapped access without hit");
   unmap_rd_a: assert property (reg_rd && !reg_wr && !mapped |=> reg_rdata == 8'h00 && !reg_hit)
      else $error("unmapped read not refused");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   readback_a: assert property (wr_s ##1 rd_same_s |=> reg_rdata == $past(reg_wdata, 2))
      else $error("read back differs from write");
   // sync lag plus the flag register needs a few cycles of margin
   ff_mask_a: assert property (!freefall_irq_enable [*5] |-> !freefall_flag)
      else $error("free-fall flag while disabled");
   mot_mask_a: assert property (!motion_enable_pin [*5] |-> !motion_flag)
      else $error("motion flag while pin low");
   ff_latch_a: assert property ((freefall_latch_mode && freefall_irq_enable) [*4] ##0 freefall_flag |=> freefall_flag)
      else $error("free-fall latch let go");
   mot_latch_a: assert property ((motion_latch_mode && motion_enable_pin) [*4] ##0 motion_flag |=> motion_flag)
      else $error("motion latch let go");
endmodule
bind ffmd_top ffmd_top_assertions ffmd_top_assertions_inst (.ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr,
   .reg_wdata, .reg_rdata, .reg_hit, .sample_valid, .x_sample, .y_sample, .z_sample, .debounce_rate_sel_lo,
   .debounce_rate_sel_hi, .freefall_irq_enable, .freefall_latch_mode, .motion_latch_mode, .motion_enable_pin,
   .freefall_flag, .motion_flag, .irq_out);

// ==== dv/ffmd_host.sv ====
// host model: drives the byte register port like the serial front end
// assumes every call starts just after a falling clock edge
`timescale 1ns/100ps
module ffmd_host (
   // clock
   input wire logic ref_clk,
   // register port
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit
);
   // ----
   // access tasks
   // ----
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // strobes stay up so accesses run back to back; idle releases them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      d = reg_rdata;
      h = reg_hit;
   endtask
   // released lines show the inverse, never a stale match
   task automatic idle;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
      @(negedge ref_clk);
   endtask
endmodule

// ==== dv/ffmd_top_tb_top.sv ====
// testbench: register access and detection runs for the detector
// assumes the fastest debounce rate, one tick every RATE3_CYC cycles, with rate code 10 held briefly
`timescale 1ns/100ps
module ffmd_top_tb_top;
   import ffmd_pkg::*;
   localparam int TK = int'(RATE3_CYC);
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr, reg_rd, reg_hit, freefall_flag, motion_flag, irq_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [SAMPLE_BITS-1:0] x_sample = 12'h000, y_sample = 12'h000, z_sample = 12'h000;
   logic freefall_irq_enable = 1'b0, motion_latch_mode = 1'b0, motion_enable_pin = 1'b0;
   logic freefall_latch_mode = 1'b0, debounce_rate_sel_lo = 1'b1;
   int fail_count = 0, total_checks = 0;
   always #4 ref_clk = ~ref_clk;
   ffmd_host ffmd_host_inst (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit);
   // fastest rate keeps the run short; the slower code only shows a missing tick
   ffmd_top ffmd_top_inst (.ref_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_hit, .sample_valid(1'b1), .x_sample, .y_sample, .z_sample, .debounce_rate_sel_lo,
      .debounce_rate_sel_hi(1'b1), .freefall_irq_enable, .freefall_latch_mode, .motion_latch_mode,
      .motion_enable_pin, .freefall_flag, .motion_flag, .irq_out);
   // ----
   // helpers
   // ----
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      logic [7:0] d;
      logic hh;
      ffmd_host_inst.rd(a, d, hh);
      chk(d, e);
      chk({7'h0, hh}, {7'h0, h});
   endtask
   task automatic axes(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
      x_sample = x;
      y_sample = y;
      z_sample = z;
      @(negedge ref_clk);
   endtask
   task automatic flags(input int n, input logic [1:0] e);
      repeat (n) begin
         if ({freefall_flag, motion_flag} === e) break;
         @(negedge ref_clk);
      end
      chk({6'h0, freefall_flag, motion_flag}, {6'h0, e});
      chk({7'h0, irq_out}, {7'h0, |e});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #(12 * TK * 8);
      fail_count++;
      test_done();
   end
   // ----
   // tests
   // ----
   initial begin
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      ffmd_host_inst.idle();
      rchk(8'h88, 8'h0E, 1'b1);
      rchk(8'h89, 8'h01, 1'b1);
      rchk(8'h8A, 8'h55, 1'b1);
      rchk(8'h8B, 8'h01, 1'b1);
      rchk(8'h0C, 8'h00, 1'b0);
      ffmd_host_inst.wr(8'h08, 8'h10);
      rchk(8'h08, 8'h10, 1'b1);
      ffmd_host_inst.wr(8'h09, 8'h03);
      rchk(8'h09, 8'h03, 1'b1);
      ffmd_host_inst.wr(8'h0A, 8'h20);
      rchk(8'h0A, 8'h20, 1'b1);
      ffmd_host_inst.wr(8'h0B, 8'h00);
      rchk(8'h0B, 8'h00, 1'b1);
      ffmd_host_inst.idle();
      $display("register test done");
      // free-fall limit 0x100, count of three with one broken run; x sits on the motion limit
      axes(12'h100, 12'h100, 12'h100);
      freefall_irq_enable = 1'b1;
      motion_enable_pin = 1'b1;
      axes(12'h0FF, 12'h0FF, 12'h0FF);
      repeat (TK) @(negedge ref_clk);
      axes(12'h200, 12'h0FF, 12'h100);
      repeat (TK + 4) @(negedge ref_clk);
      flags(1, 2'b00);
      axes(12'h0FF, 12'h0FF, 12'h0FF);
      repeat (2 * TK) @(negedge ref_clk);
      flags(1, 2'b00);
      flags(TK + 8, 2'b10);
      axes(12'h0FF, 12'h100, 12'h0FF);
      flags(TK + 8, 2'b00);
      $display("free-fall test done");
      // motion limit 0x200, zero debounce acts as one, latched; rate code 10 holds back the tick
      freefall_irq_enable = 1'b0;
      freefall_latch_mode = 1'b1;
      motion_latch_mode = 1'b1;
      debounce_rate_sel_lo = 1'b0;
      axes(12'h200, 12'h100, 12'h100);
      repeat (TK + 8) @(negedge ref_clk);
      flags(1, 2'b00);
      // back to code 11: the counter is already past its end, so the tick comes at once
      debounce_rate_sel_lo = 1'b1;
      axes(12'h100, 12'h100, 12'h201);
      flags(8, 2'b01);
      axes(12'h000, 12'h000, 12'h000);
      repeat (3 * TK + 8) @(negedge ref_clk);
      flags(1, 2'b01);
      motion_enable_pin = 1'b0;
      flags(8, 2'b00);
      $display("motion test done");
      // free-fall latch: detected while masked, raised by the enable, held past a failed sample
      freefall_irq_enable = 1'b1;
      flags(8, 2'b10);
      axes(12'h0FF, 12'h100, 12'h0FF);
      repeat (TK + 8) @(negedge ref_clk);
      flags(1, 2'b10);
      freefall_irq_enable = 1'b0;
      flags(8, 2'b00);
      $display("latch test done");
      test_done();
   end
endmodule
